// File: logic/spi_slave_pkg.sv
package spi_slave_pkg;

	// framing of the serial link
	localparam int WORD_BITS = 16;
	localparam int FRAME_BITS = 32;
	localparam int ADDR_BITS = 15;
	localparam int BIT_CNT_W = 4;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_RESET = 4'h0;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_STEP = 4'h1;
	localparam logic [BIT_CNT_W-1:0] BIT_LAST = 4'hF;
	localparam int RW_BIT = 15;

	// locally held interface registers
	localparam logic [ADDR_BITS-1:0] ADDR_IDENTITY = 15'h0009;
	localparam logic [ADDR_BITS-1:0] ADDR_SELECT = 15'h000A;
	localparam int GROUP_MSB = 15;
	localparam int GROUP_LSB = 8;
	localparam int ID_MSB = 7;
	localparam int ID_LSB = 0;
	localparam int ID_BITS = 8;
	localparam logic [ID_BITS-1:0] ID_NONE = 8'h00;
	localparam logic [WORD_BITS-1:0] IDENTITY_RESET = 16'h0000;
	localparam logic [WORD_BITS-1:0] SELECT_RESET = 16'h0000;
	localparam logic [WORD_BITS-1:0] WORD_ZERO = 16'h0000;
	localparam logic [FRAME_BITS-1:0] FRAME_ZERO = 32'h0000_0000;
	localparam logic ACTIVE_RESET = 1'b1;

	// write buffer toward the device core
	localparam int FIFO_WIDTH_DEF = 32;
	localparam int FIFO_DEPTH_DEF = 32;

	// each word of a frame is either the command word or the data word
	typedef enum logic [0:0] {
		PH_CMD,
		PH_DATA
	} phase_t;

endpackage

// File: logic/word_fifo.sv
module word_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);

	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W+1)'(DEPTH);
	localparam logic [PTR_W:0] CNT_ZERO = '0;
	localparam logic [PTR_W:0] CNT_ONE = (PTR_W+1)'(1);
	localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

	initial begin
		if (DEPTH < 2 || (1 << PTR_W) != DEPTH || WIDTH < 1)
			$error("word_fifo: DEPTH must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PTR_W-1:0] wr_ptr_q;
	logic [PTR_W-1:0] rd_ptr_q;
	logic [PTR_W:0] count_q;
	logic [PTR_W:0] count_d;
	logic out_valid_q;
	logic [WIDTH-1:0] out_data_q;
	logic push;
	logic pop;

	// output register counts as one more slot beyond the memory
	assign in_ready_out = (count_q != DEPTH_CNT);
	assign push = in_valid_in & in_ready_out;
	assign pop = (count_q != CNT_ZERO) & (~out_valid_q | out_ready_in);
	assign out_valid_out = out_valid_q;
	assign out_data_out = out_data_q;

	always_comb begin
		count_d = count_q;
		if (push & ~pop)
			count_d = count_q + CNT_ONE;
		else if (pop & ~push)
			count_d = count_q - CNT_ONE;
	end

	always_ff @(posedge clk_in) begin
		if (push)
			mem_q[wr_ptr_q] <= in_data_in;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= CNT_ZERO;
		end else begin
			if (push)
				wr_ptr_q <= wr_ptr_q + PTR_ONE;
			if (pop)
				rd_ptr_q <= rd_ptr_q + PTR_ONE;
			count_q <= count_d;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			out_valid_q <= 1'b0;
			out_data_q <= '0;
		end else begin
			if (pop)
				out_data_q <= mem_q[rd_ptr_q];
			out_valid_q <= pop | (out_valid_q & ~out_ready_in);
		end
	end

endmodule

// File: logic/sensor_spi_slave.sv
// Behaviour
// RULE1: sample mosi on each rising sck edge.
// RULE2: update miso on each falling sck edge.
// RULE3: drive miso only while select_n low, otherwise release it.
// RULE4: every access opens with a 16-bit command word, msb 1 writes, 0 reads.
// RULE5: word boundaries come from counting sck edges only.
// RULE6: a write shifts out the old register contents while new data arrives.
// RULE7: select_n gates transfers only, never alters interface register contents.
// RULE8: read data starts shifting out after the 16 command clocks.
// RULE9: mosi bits during read data form the next command word.
// RULE10: a write command fetches the present register contents for readback.
// RULE11: a finished write is echoed whole on miso during the next transfer.
// RULE12: select_n high clears the sck bit counter.
// RULE13: master asserts at most one select_n at a time.
// RULE14: ready pin can be set to open drain for wired-and use.
// RULE15: ready pin signals a finished measurement.
// RULE16: write to device_identity_assign while selected stores group id and local id.
// RULE17: writing a nonzero local id deactivates the active device.
// RULE18: write to device_select_by_id activates only the device whose local id matches.
// RULE19: master holds select_n low through the whole selection write.
// RULE20: upper selection byte is a group id compared with local group id.
// RULE21: master gives each device a unique local id one at a time.
// RULE22: master resets the device after power-up before talking to it.
// RULE23: words are synchronised into the system clock and acted on after 16 clocks.
// RULE24: system clock runs the logic independent of sck.
// RULE25: words shift most significant bit first on mosi and miso.
// RULE26: an inactive device releases miso and ignores all but selection writes.
module sensor_spi_slave #(
	parameter int FIFO_DEPTH = spi_slave_pkg::FIFO_DEPTH_DEF
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic sck_in,
	input wire logic mosi_in,
	input wire logic select_n_in,
	output logic miso_out,
	output logic miso_oe_out,
	input wire logic ready_open_drain_in,
	input wire logic meas_done_in,
	input wire logic ready_clear_in,
	output logic ready_out,
	output logic ready_oe_out,
	output logic [spi_slave_pkg::ADDR_BITS-1:0] reg_addr_out,
	output logic reg_rd_out,
	input wire logic [spi_slave_pkg::WORD_BITS-1:0] reg_rdata_in,
	output logic cfg_valid_out,
	input wire logic cfg_ready_in,
	output logic [spi_slave_pkg::ADDR_BITS-1:0] cfg_addr_out,
	output logic [spi_slave_pkg::WORD_BITS-1:0] cfg_data_out,
	output logic cfg_overflow_out,
	output logic active_out,
	output logic [spi_slave_pkg::ID_BITS-1:0] local_id_out
);
	import spi_slave_pkg::*;

	initial begin
		if (FIFO_DEPTH < 2 || (1 << $clog2(FIFO_DEPTH)) != FIFO_DEPTH)
			$error("sensor_spi_slave: FIFO_DEPTH must be a power of two of at least 2");
		// the frame logic assumes two words per frame and a counter that wraps once per word
		if (FRAME_BITS != 2 * WORD_BITS || (1 << BIT_CNT_W) != WORD_BITS ||
			int'(BIT_LAST) != WORD_BITS - 1)
			$error("sensor_spi_slave: framing constants do not fit the bit counter");
	end

	// pin synchronisers; logic reads only the second stage, plus a third sck stage for edge detection
	logic sck_ff1_q;
	logic sck_ff2_q;
	logic sck_prev_q;
	logic mosi_ff1_q;
	logic mosi_ff2_q;
	logic seln_ff1_q;
	logic seln_ff2_q;
	logic od_ff1_q;
	logic od_ff2_q;

	always_ff @(posedge mclk_in) begin // [RULE24]
		if (rst_in) begin
			sck_ff1_q <= 1'b0;
			sck_ff2_q <= 1'b0;
			sck_prev_q <= 1'b0;
			mosi_ff1_q <= 1'b0;
			mosi_ff2_q <= 1'b0;
			seln_ff1_q <= 1'b1;
			seln_ff2_q <= 1'b1;
		end else begin
			sck_ff1_q <= sck_in;
			sck_ff2_q <= sck_ff1_q;
			sck_prev_q <= sck_ff2_q;
			mosi_ff1_q <= mosi_in;
			mosi_ff2_q <= mosi_ff1_q;
			seln_ff1_q <= select_n_in;
			seln_ff2_q <= seln_ff1_q;
		end
	end

	// the strap pin is asynchronous too and gets its own pair of stages
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			od_ff1_q <= 1'b0;
			od_ff2_q <= 1'b0;
		end else begin
			od_ff1_q <= ready_open_drain_in;
			od_ff2_q <= od_ff1_q;
		end
	end

	logic selected;
	logic sck_rise;
	logic sck_fall;
	logic rise_take;
	logic word_done;
	logic [WORD_BITS-1:0] rx_word;

	logic [BIT_CNT_W-1:0] bit_cnt_q;
	logic [WORD_BITS-1:0] rx_q;
	phase_t phase_q;
	logic [WORD_BITS-1:0] cmd_q;
	logic [FRAME_BITS-1:0] out_q;
	logic echo_q;
	logic miso_q;
	logic miso_oe_q;
	logic fetch1_q;
	logic fetch2_q;
	logic [ADDR_BITS-1:0] reg_addr_q;
	logic reg_rd_q;
	logic [WORD_BITS-1:0] identity_q;
	logic [WORD_BITS-1:0] select_q;
	logic active_q;
	logic ready_flag_q;
	logic ready_q;
	logic ready_oe_q;
	logic overflow_q;

	assign selected = ~seln_ff2_q;
	// mosi passes the same two stages as sck, so both line up at the edge
	assign sck_rise = sck_ff2_q & ~sck_prev_q;
	assign sck_fall = ~sck_ff2_q & sck_prev_q;
	assign rise_take = sck_rise & selected;
	assign rx_word = {rx_q[WORD_BITS-2:0], mosi_ff2_q}; // [RULE1] [RULE25]
	assign word_done = rise_take && (bit_cnt_q == BIT_LAST); // [RULE5] [RULE23]

	// counter only; deselect never touches the shift or stored registers
	always_ff @(posedge mclk_in) begin
		if (rst_in || !selected)
			bit_cnt_q <= BIT_CNT_RESET; // [RULE12] [RULE7]
		else if (sck_rise)
			bit_cnt_q <= bit_cnt_q + BIT_CNT_STEP; // [RULE5]
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in)
			rx_q <= WORD_ZERO;
		else if (rise_take)
			rx_q <= rx_word; // [RULE1]
	end

	// a lost sck pulse is healed by a select_n high pulse
	always_ff @(posedge mclk_in) begin
		if (rst_in || !selected) begin
			phase_q <= PH_CMD; // [RULE12]
		end else if (word_done) begin
			case (phase_q)
				PH_CMD: begin
					if (rx_word[RW_BIT])
						phase_q <= PH_DATA; // [RULE4]
				end
				PH_DATA: begin
					phase_q <= PH_CMD;
				end
				default: begin
					phase_q <= PH_CMD;
				end
			endcase
		end
	end

	logic cmd_done;
	logic wr_done;
	logic [ADDR_BITS-1:0] wr_addr;
	logic [ID_BITS-1:0] sel_id;
	logic [ID_BITS-1:0] sel_group;
	logic id_match;

	assign cmd_done = word_done && (phase_q == PH_CMD);
	assign wr_done = word_done && (phase_q == PH_DATA);
	assign wr_addr = cmd_q[ADDR_BITS-1:0];
	assign sel_id = rx_word[ID_MSB:ID_LSB];
	assign sel_group = rx_word[GROUP_MSB:GROUP_LSB];
	// id 0 in the selection word addresses a whole group, plus any device whose local id is still 0
	assign id_match = (sel_id == identity_q[ID_MSB:ID_LSB]) ||
		(sel_id == ID_NONE && sel_group == identity_q[GROUP_MSB:GROUP_LSB]); // [RULE18] [RULE20]

	always_ff @(posedge mclk_in) begin
		if (rst_in)
			cmd_q <= WORD_ZERO;
		else if (cmd_done)
			cmd_q <= rx_word; // [RULE4] [RULE9]
	end

	// register fetch: address out, answer sampled one cycle after the strobe
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			fetch1_q <= 1'b0;
			fetch2_q <= 1'b0;
			reg_addr_q <= '0;
			reg_rd_q <= 1'b0;
		end else begin
			fetch1_q <= cmd_done; // [RULE10] [RULE8]
			fetch2_q <= fetch1_q;
			reg_rd_q <= cmd_done & active_q; // [RULE26]
			if (cmd_done)
				reg_addr_q <= rx_word[ADDR_BITS-1:0];
		end
	end

	logic [WORD_BITS-1:0] fetch_data;

	always_comb begin
		if (reg_addr_q == ADDR_IDENTITY)
			fetch_data = identity_q;
		else if (reg_addr_q == ADDR_SELECT)
			fetch_data = select_q;
		else
			fetch_data = reg_rdata_in;
	end

	// a pending echo owns the next 32 clocks; the fetched word is dropped then
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			out_q <= FRAME_ZERO;
			echo_q <= 1'b0;
		end else if (wr_done) begin
			out_q <= {cmd_q, rx_word}; // [RULE11]
			echo_q <= 1'b1;
		end else if (fetch2_q) begin
			if (!echo_q)
				out_q <= {fetch_data, WORD_ZERO}; // [RULE6] [RULE8]
			echo_q <= 1'b0;
		end else if (sck_fall && selected) begin
			out_q <= {out_q[FRAME_BITS-2:0], 1'b0}; // [RULE25] [RULE6]
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in)
			miso_q <= 1'b0;
		else if (sck_fall && selected)
			miso_q <= out_q[FRAME_BITS-1]; // [RULE2]
	end

	// enable follows the synchronised select, so release lags the pin by about three clocks
	always_ff @(posedge mclk_in) begin
		if (rst_in)
			miso_oe_q <= 1'b0;
		else
			miso_oe_q <= selected & active_q; // [RULE3] [RULE26]
	end

	// addressing registers and the active flag
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			identity_q <= IDENTITY_RESET;
			select_q <= SELECT_RESET;
			active_q <= ACTIVE_RESET;
		end else if (wr_done) begin
			if (wr_addr == ADDR_SELECT) begin
				select_q <= rx_word;
				active_q <= id_match; // [RULE18] [RULE20]
			end else if (active_q && wr_addr == ADDR_IDENTITY) begin
				identity_q <= rx_word; // [RULE16]
				if (sel_id != ID_NONE)
					active_q <= 1'b0; // [RULE17]
			end
		end
	end

	// other accepted writes go to the core through the buffer
	logic fifo_in_valid;
	logic fifo_in_ready;

	assign fifo_in_valid = wr_done && active_q && wr_addr != ADDR_SELECT &&
		wr_addr != ADDR_IDENTITY; // [RULE26] [RULE23]

	// serial link cannot be stalled; a full buffer loses the word and says so
	always_ff @(posedge mclk_in) begin
		if (rst_in)
			overflow_q <= 1'b0;
		else if (fifo_in_valid && !fifo_in_ready)
			overflow_q <= 1'b1;
	end

	logic [FIFO_WIDTH_DEF-1:0] fifo_out_data;

	word_fifo #(
		.WIDTH(FIFO_WIDTH_DEF),
		.DEPTH(FIFO_DEPTH)
	) u_wr_fifo (
		.clk_in(mclk_in),
		.rst_in(rst_in),
		.in_valid_in(fifo_in_valid),
		.in_ready_out(fifo_in_ready),
		.in_data_in({cmd_q, rx_word}),
		.out_valid_out(cfg_valid_out),
		.out_ready_in(cfg_ready_in),
		.out_data_out(fifo_out_data)
	);

	assign cfg_addr_out = fifo_out_data[FRAME_BITS-WORD_BITS+ADDR_BITS-1:FRAME_BITS-WORD_BITS];
	assign cfg_data_out = fifo_out_data[WORD_BITS-1:0];

	// ready flag: a new measurement end wins over a clear in the same cycle
	always_ff @(posedge mclk_in) begin
		if (rst_in)
			ready_flag_q <= 1'b0;
		else if (meas_done_in)
			ready_flag_q <= 1'b1; // [RULE15]
		else if (ready_clear_in)
			ready_flag_q <= 1'b0;
	end

	// open drain: pull low while busy, release when done so the bus ands all
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			ready_q <= 1'b0;
			ready_oe_q <= 1'b1;
		end else if (od_ff2_q) begin
			ready_q <= 1'b0; // [RULE14]
			ready_oe_q <= ~ready_flag_q;
		end else begin
			ready_q <= ready_flag_q; // [RULE15]
			ready_oe_q <= 1'b1;
		end
	end

	assign miso_out = miso_q;
	assign miso_oe_out = miso_oe_q;
	assign ready_out = ready_q;
	assign ready_oe_out = ready_oe_q;
	assign reg_addr_out = reg_addr_q;
	assign reg_rd_out = reg_rd_q;
	assign cfg_overflow_out = overflow_q;
	assign active_out = active_q;
	assign local_id_out = identity_q[ID_MSB:ID_LSB];

endmodule

// File: testbench/spi_slave_monitor.sv
module spi_slave_monitor
	import spi_slave_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic sck_in,
	input wire logic select_n_in,
	input wire logic miso_out,
	input wire logic miso_oe_out,
	input wire logic ready_open_drain_in,
	input wire logic meas_done_in,
	input wire logic ready_out,
	input wire logic ready_oe_out,
	input wire logic reg_rd_out,
	input wire logic cfg_valid_out,
	input wire logic cfg_ready_in,
	input wire logic [ADDR_BITS-1:0] cfg_addr_out,
	input wire logic [WORD_BITS-1:0] cfg_data_out,
	input wire logic active_out,
	input wire logic [ID_BITS-1:0] local_id_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);
	a_oe_needs_sel: assert property (select_n_in [*5] |-> !miso_oe_out)
		else $error("miso driven while deselected");
	a_oe_needs_active: assert property ((!active_out) [*5] |-> !miso_oe_out)
		else $error("miso driven while inactive");
	a_fetch_active: assert property (reg_rd_out |-> active_out)
		else $error("fetch while inactive");
	// synchroniser lag puts the update two or three cycles behind the pin
	a_miso_on_fall: assert property ($changed(miso_out) |-> !$past(sck_in, 2) || !$past(sck_in, 3))
		else $error("miso moved without falling sck");
	// the flag takes one clock and the pin register one more
	a_ready_push: assert property ((!ready_open_drain_in) [*4] ##0 meas_done_in |-> ##2 ready_out && ready_oe_out)
		else $error("push-pull ready not raised");
	a_ready_drain: assert property (ready_open_drain_in [*4] ##0 meas_done_in |-> ##2 !ready_out && !ready_oe_out)
		else $error("open-drain ready not released");
	a_cfg_holds: assert property (cfg_valid_out && !cfg_ready_in |=> cfg_valid_out && $stable(cfg_data_out)
		&& $stable(cfg_addr_out))
		else $error("stalled head changed");
	a_id_when_active: assert property ($changed(local_id_out) |-> $past(active_out))
		else $error("identity taken while inactive");
	a_id_deactivates: assert property ($changed(local_id_out) && local_id_out != ID_NONE |-> !active_out)
		else $error("nonzero id left device active");
	c_fetch: cover property (reg_rd_out);
	c_pop: cover property (cfg_valid_out && cfg_ready_in);
	c_deact: cover property ($fell(active_out));
endmodule

bind sensor_spi_slave spi_slave_monitor u_mon (.*);

// File: testbench/spi_master_model.sv
module spi_master_model (
	input wire logic clk_in,
	input wire logic miso_in,
	output logic sck_out,
	output logic mosi_out,
	output logic sel_n_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		sck_out = 1'b0;
		mosi_out = 1'b0;
		sel_n_out = 1'b1;
	end
	// msb first, shift on fall, sample late in the high phase where miso is settled
	// called on a rising clock edge; sck idles low between words, giving an 8-clock period
	task automatic word(input logic [15:0] w, input int n, output logic [15:0] r);
		r = 16'h0000;
		for (int i = 15; i > 15 - n; i--) begin
			mosi_out <= w[i];
			repeat (4) @(posedge clk_in);
			sck_out <= 1'b1;
			repeat (4) @(posedge clk_in);
			r[i] = miso_in;
			sck_out <= 1'b0;
		end
	endtask
	// single device on the bus, so one select at a time; held low across selection writes
	task automatic sel(input logic v);
		@(posedge clk_in);
		sck_out <= 1'b0;
		repeat (4) @(posedge clk_in);
		sel_n_out <= v;
		repeat (8) @(posedge clk_in);
	endtask
endmodule

// File: testbench/sensor_spi_slave_tb.sv
module sensor_spi_slave_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import spi_slave_pkg::*;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic ready_open_drain_in = 1'b0;
	logic meas_done_in = 1'b0;
	logic ready_clear_in = 1'b0;
	logic cfg_ready_in = 1'b0;
	logic flip_q = 1'b0;
	logic sck_in, mosi_in, select_n_in, miso_out, miso_oe_out, ready_out, ready_oe_out, miso_line;
	logic reg_rd_out, cfg_valid_out, cfg_overflow_out, active_out;
	logic [ADDR_BITS-1:0] reg_addr_out, cfg_addr_out;
	logic [WORD_BITS-1:0] cfg_data_out, r, d, v;
	logic [WORD_BITS-1:0] reg_rdata_in = 16'h0000;
	logic [ID_BITS-1:0] local_id_out;
	logic [31:0] q[$];
	logic [16:0] sel_tab[6] = '{17'h00005, 17'h10007, 17'h00005, 17'h13400, 17'h03500, 17'h10007};
	int err_count = 0;
	int checks = 0;
	int n;
	always #50 mclk_in = ~mclk_in;
	// a released line shows a toggling pattern, never the last bit
	assign miso_line = miso_oe_out ? miso_out : flip_q;
	always @(posedge mclk_in) begin
		flip_q <= ~flip_q;
		reg_rdata_in <= reg_rd_out ? rv(reg_addr_out) : ~reg_rdata_in;
	end
	spi_master_model u_mst (.clk_in(mclk_in), .miso_in(miso_line), .sck_out(sck_in), .mosi_out(mosi_in),
		.sel_n_out(select_n_in));
	sensor_spi_slave #(.FIFO_DEPTH(4)) u_dut (.*);
	function automatic logic [15:0] rv(input logic [14:0] a);
		return {a[7:0], ~a[7:0]};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic close_out();
		$display("checks=%0d errors=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic rd(input logic [14:0] a);
		u_mst.word({1'b0, a}, 16, r);
	endtask
	task automatic wr(input logic [14:0] a, input logic [15:0] w);
		u_mst.word({1'b1, a}, 16, r);
		u_mst.word(w, 16, r);
		repeat (6) @(posedge mclk_in);
	endtask
	task automatic pulse(input logic c, input logic [1:0] e);
		@(posedge mclk_in);
		meas_done_in <= !c;
		ready_clear_in <= c;
		@(posedge mclk_in);
		meas_done_in <= 1'b0;
		ready_clear_in <= 1'b0;
		repeat (2) @(negedge mclk_in);
		chk({ready_out, ready_oe_out}, e);
	endtask
	initial begin
		logic [14:0] a;
		void'($urandom(32'h450fcf6c));
		repeat (4) @(posedge mclk_in);
		rst_in <= 1'b0;
		repeat (3) @(posedge mclk_in);
		chk({active_out, local_id_out, miso_oe_out, ready_oe_out}, 32'h401);
		u_mst.sel(1'b0);
		d = IDENTITY_RESET;
		rd(ADDR_IDENTITY);
		repeat (6) begin
			a = {7'h01, 8'($urandom)};
			rd(a);
			chk(r, d);
			d = rv(a);
		end
		// back-to-back writes: each data slot after the first echoes the previous write
		for (int k = 0; k < 6; k++) begin
			a = {7'h02, 8'(k)};
			v = 16'($urandom);
			wr(a, v);
			chk(r, k == 0 ? {16'h0000, rv(a)} : {16'h0000, d});
			d = v;
			if (k < 5)
				q.push_back({1'b0, a, v});
			if (k == 4)
				chk(cfg_overflow_out, 32'h0);
		end
		rd(15'h0100);
		chk(r, {1'b1, a});
		rd(15'h0101);
		chk(r, d);
		rd(15'h0100);
		chk(r, rv(15'h0101));
		chk(cfg_overflow_out, 32'h1);
		n = 0;
		repeat (60) begin
			@(posedge mclk_in);
			cfg_ready_in <= 1'($urandom);
			@(negedge mclk_in);
			if (cfg_valid_out === 1'b1 && cfg_ready_in && n < 5) begin
				chk({1'b0, cfg_addr_out, cfg_data_out}, q[n]);
				n++;
			end
		end
		chk(n, 5);
		@(posedge mclk_in);
		u_mst.word(16'h8123, 7, r);
		u_mst.sel(1'b1);
		u_mst.sel(1'b0);
		rd(ADDR_IDENTITY);
		rd(15'h0100);
		chk(r, IDENTITY_RESET);
		chk({active_out, local_id_out}, 32'h100);
		wr(ADDR_IDENTITY, 16'h3407);
		chk({active_out, local_id_out, miso_oe_out}, 32'h00E);
		wr(ADDR_IDENTITY, 16'h3499);
		chk(local_id_out, 32'h07);
		foreach (sel_tab[i]) begin
			wr(ADDR_SELECT, sel_tab[i][15:0]);
			chk(active_out, sel_tab[i][16]);
		end
		rd(15'h0100);
		rd(ADDR_IDENTITY);
		rd(15'h0100);
		chk(r, 16'h3407);
		pulse(1'b0, 2'b11);
		pulse(1'b1, 2'b01);
		ready_open_drain_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		pulse(1'b0, 2'b00);
		pulse(1'b1, 2'b01);
		close_out();
	end
endmodule
